// File: hub_port_consts.svh
// constants of the hub port link and status block
`ifndef HUB_PORT_CONSTS_SVH
`define HUB_PORT_CONSTS_SVH
`define CLK_HZ          10000000
`define NUM_PORTS       5
`define NUM_PAIR        4
`define NUM_LAMPS       7
`define PREAMBLE_BITS   56
`define SFD_BITS        8
`define MIN_PKT_BITS    96
`define QUIET_BITS      8
`define RECOVER_EVENTS  3
`define LINK_FAIL_MS    100
`define LINK_PULSE_MS   16
`define LINK_FAIL_CYC   (`LINK_FAIL_MS * (`CLK_HZ / 1000))
`define LINK_PULSE_CYC  (`LINK_PULSE_MS * (`CLK_HZ / 1000))
`define BLINK_BIT       20
`define LFSR_SEED       7'h7f
`define REG_CTRL        8'h00
`define REG_STAT        8'h04
`define CTRL_W          6
`define CTRL_RST        6'h20
`define CTRL_LCO_LSB    0
`define CTRL_SYNC_BIT   4
`define CTRL_LOCAL_BIT  5
`define STAT_RX_LSB     0
`define STAT_LF_LSB     5
`define STAT_COL_BIT    9
`define STAT_LCOL_BIT   10
`define STAT_BUSY_LSB   11
`define SYNC_W          16
`define SYNC_RST        16'h8000
`define SY_RX           0
`define SY_LP           5
`define SY_COL          9
`define SY_SEC          10
`define SY_SHC          15
`endif

// File: hub_port_pkg.sv
// types of the hub port link and status block
`include "hub_port_consts.svh"
package hub_port_pkg;
	typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_DATA, TX_PAD} tx_state_t;
	typedef enum logic [2:0] {
		L_OFF, L_GREEN, L_RED, L_BLINK_G, L_BLINK_R, L_ALT
	} lamp_mode_t;
	typedef struct packed {
		tx_state_t   state;
		logic [6:0]  bitCnt;
		logic        padPh;
		logic [17:0] pulseTmr;
		logic [6:0]  lfsr;
		logic [1:0]  symbol;
		logic        drive;
		logic        nrzOut;
	} engine_st_t;
	typedef struct packed {
		logic [`SYNC_W-1:0]            syncA;
		logic [`SYNC_W-1:0]            syncB;
		logic [`NUM_PORTS-1:0]         rxActive;
		logic [`NUM_PORTS-1:0]         rxPrev;
		logic [`NUM_PORTS-1:0][3:0]    quietCnt;
		logic [`NUM_PAIR-1:0]          lpPrev;
		logic [`NUM_PAIR-1:0]          linkFail;
		logic [`NUM_PAIR-1:0][19:0]    failTmr;
		logic [`NUM_PAIR-1:0][1:0]     recovCnt;
		logic                          colDrive;
		logic                          collision;
		logic                          chainHead;
		logic                          bpActN;
		logic                          bpDataN;
		logic                          bpDrvN;
		logic [20:0]                   blinkCnt;
		logic [`NUM_LAMPS-1:0]         lampLevel;
		logic [`NUM_LAMPS-1:0]         lampOen;
		logic [`CTRL_W-1:0]            ctrl;
		logic                          wrPend;
		logic                          wrCtrl;
		logic [31:0]                   rdData;
	} hub_st_t;
endpackage : hub_port_pkg

// File: port_link_if.sv
// carrier between the hub top and one frame engine
interface port_link_if;
	logic       txEn;
	logic       txData;
	logic       txReady;
	logic       regen;
	logic       scramble;
	logic       allowTx;
	logic       pulseEn;
	logic [1:0] symbol;
	logic       drive;
	logic       nrzOut;
	logic       busy;
	modport core (output txEn, txData, regen, scramble, allowTx, pulseEn,
		input txReady, symbol, drive, nrzOut, busy);
	modport engine (input txEn, txData, regen, scramble, allowTx, pulseEn,
		output txReady, symbol, drive, nrzOut, busy);
endinterface : port_link_if

// File: port_frame_tx.sv
// per-port frame engine: preamble, pad, scramble, manchester, link pulse
`include "hub_port_consts.svh"
module port_frame_tx
	import hub_port_pkg::*;
#(
	parameter int PULSE_CYCLES = `LINK_PULSE_CYC // idle link pulse period
) (
	input wire logic    clk_sys, // system clock
	input wire logic    rst,     // async reset, active high
	input wire logic    ce,      // clock enable
	port_link_if.engine lnk      // core-side link
);
	localparam logic [6:0] PRE_LAST = 7'(`PREAMBLE_BITS + `SFD_BITS - 1);
	localparam logic [6:0] PKT_MIN  = 7'(`MIN_PKT_BITS);
	localparam logic [6:0] PAD_LAST = 7'(`MIN_PKT_BITS - 1);
	localparam engine_st_t ENG_RST  = '{state: TX_IDLE, lfsr: `LFSR_SEED,
		padPh: 1'b1, default: '0};

	engine_st_t st_ff;
	engine_st_t nxt_st;
	logic       bitOut;
	logic       sending;
	logic       bitSent;

	always_comb begin
		nxt_st = st_ff;
		bitOut = 1'b0;
		sending = 1'b0;
		nxt_st.lfsr = {st_ff.lfsr[5:0], st_ff.lfsr[6] ^ st_ff.lfsr[5]};
		unique case (st_ff.state)
			TX_IDLE: begin
				nxt_st.bitCnt = '0;
				nxt_st.padPh = 1'b1;
				if (lnk.txEn && lnk.allowTx) begin
					nxt_st.state = lnk.regen ? TX_PRE : TX_DATA;
				end
			end
			TX_PRE: begin
				sending = 1'b1;
				// alternating bits, last one doubled to close the delimiter
				bitOut = ~st_ff.bitCnt[0] | (st_ff.bitCnt == PRE_LAST);
				nxt_st.bitCnt = st_ff.bitCnt + 7'h01;
				if (st_ff.bitCnt == PRE_LAST) begin
					nxt_st.state = TX_DATA;
				end
			end
			TX_DATA, TX_PAD: begin
				if (lnk.txEn && st_ff.state == TX_DATA) begin
					sending = 1'b1;
					bitOut = lnk.txData;
					if (st_ff.bitCnt < PKT_MIN) begin
						nxt_st.bitCnt = st_ff.bitCnt + 7'h01;
					end
				end else if (st_ff.bitCnt < PKT_MIN) begin
					// jam follows the last data bit with no idle gap
					sending = 1'b1;
					bitOut = st_ff.padPh;
					nxt_st.padPh = ~st_ff.padPh;
					nxt_st.bitCnt = st_ff.bitCnt + 7'h01;
					nxt_st.state = TX_PAD;
					if (st_ff.bitCnt == PAD_LAST) begin
						nxt_st.state = TX_IDLE;
					end
				end else begin
					nxt_st.state = TX_IDLE;
				end
			end
		endcase
		// a port that loses its link is cut off even mid-frame
		if (!lnk.allowTx && st_ff.state != TX_IDLE) begin
			nxt_st.state = TX_IDLE;
			sending = 1'b0;
		end
		bitSent = bitOut ^ (lnk.scramble & st_ff.lfsr[0]);
		nxt_st.drive = sending;
		nxt_st.nrzOut = sending & bitSent;
		// first half, second half: a one rises mid-bit
		nxt_st.symbol = sending ? (bitSent ? 2'b01 : 2'b10) : 2'b00;
		if (st_ff.state != TX_IDLE || !lnk.pulseEn) begin
			nxt_st.pulseTmr = '0;
		end else if (st_ff.pulseTmr == 18'(PULSE_CYCLES - 1)) begin
			nxt_st.pulseTmr = '0;
			nxt_st.symbol = 2'b11;
			nxt_st.drive = 1'b1;
		end else begin
			nxt_st.pulseTmr = st_ff.pulseTmr + 18'h0_0001;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_ff <= ENG_RST;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	assign lnk.txReady = (st_ff.state == TX_DATA);
	assign lnk.busy    = (st_ff.state != TX_IDLE);
	assign lnk.symbol  = st_ff.symbol;
	assign lnk.drive   = st_ff.drive;
	assign lnk.nrzOut  = st_ff.nrzOut;
endmodule : port_frame_tx

// File: hub_port_link_and_status.sv
// hub port framing, link supervision, collision, security and lamps
`include "hub_port_consts.svh"
module hub_port_link_and_status
	import hub_port_pkg::*;
#(
	parameter int LINK_FAIL_CYCLES  = `LINK_FAIL_CYC,  // silence timeout
	parameter int LINK_PULSE_CYCLES = `LINK_PULSE_CYC, // link pulse period
	parameter int BLINK_BIT         = `BLINK_BIT       // lamp phase bit
) (
	input  wire logic                    clk_sys,       // system clock
	input  wire logic                    rst,           // async reset
	input  wire logic                    ce,            // clock enable
	input  wire logic                    hsel,          // slave select
	input  wire logic [31:0]             haddr,         // byte address
	input  wire logic [1:0]              htrans,        // transfer type
	input  wire logic                    hwrite,        // write not read
	input  wire logic [2:0]              hsize,         // transfer size
	input  wire logic [31:0]             hwdata,        // write data
	input  wire logic                    hready,        // bus ready
	output logic                         hreadyout,     // slave ready
	output logic                         hresp,         // always okay
	output logic [31:0]                  hrdata,        // read data
	input  wire logic [`NUM_PORTS-1:0]   coreTxEn,      // core frame valid
	input  wire logic [`NUM_PORTS-1:0]   coreTxData,    // core NRZ bits
	output logic [`NUM_PORTS-1:0]        coreTxReady,   // bit taken
	input  wire logic                    coreRxEn,      // received frame
	input  wire logic                    coreRxData,    // received NRZ
	output logic                         coreRxReady,   // rx bit taken
	input  wire logic [`NUM_PORTS-1:0]   network_input_pair, // above sq.
	input  wire logic [`NUM_PAIR-1:0]    linkPulseIn,   // pulse detected
	input  wire logic                    attach_collision_pair, // col in
	input  wire logic [`NUM_PAIR-1:0]    port_scramble_in, // pair secure
	input  wire logic                    secure_attach_port_in, // shared
	input  wire logic [`NUM_PAIR-1:0]    polarityRev,   // reversed pair
	input  wire logic [`NUM_PORTS-1:0]   partitioned,   // isolated port
	input  wire logic                    rxJabber,      // attach jabber
	input  wire logic                    fifoError,     // fifo over/under
	input  wire logic                    codeViolation, // manchester err
	input  wire logic                    transceiver_jabber_lockup, // lock
	output logic [`NUM_PAIR-1:0][1:0]    pairTxSymbol,  // half-bit pairs
	output logic [1:0]                   attach_output_pair, // half bits
	output logic [`NUM_PORTS-1:0]        txDrive,       // line driven
	input  wire logic                    shared_collision_line_n_i, // lvl
	output logic                         shared_collision_line_n_o, // 0
	output logic                         shared_collision_line_n_oe_n,
	output logic                         backplane_activity_n,    // busy
	output logic                         backplane_serial_data_n, // data
	output logic                         backplane_data_drive_n,  // drive
	output logic                         chain_head_select, // first pos
	output logic [`NUM_PAIR-1:0]         pair_port_lamp,       // level
	output logic [`NUM_PAIR-1:0]         pair_port_lamp_oe_n,  // enable
	output logic                         attach_port_lamp,     // level
	output logic                         attach_port_lamp_oe_n, // enable
	output logic                         collision_fifo_lamp,  // level
	output logic                         collision_fifo_lamp_oe_n,
	output logic                         jam_violation_lamp,   // level
	output logic                         jam_violation_lamp_oe_n
);
	localparam int NENG = `NUM_PORTS + 1;
	localparam hub_st_t HUB_RST = '{linkFail: '1, ctrl: `CTRL_RST,
		syncA: `SYNC_RST, syncB: `SYNC_RST, bpActN: 1'b1, bpDataN: 1'b1,
		bpDrvN: 1'b1, lampOen: '1, default: '0};

	hub_st_t                  st_ff;
	hub_st_t                  nxt_st;
	logic [`NUM_PORTS-1:0]    rxSq;
	logic [`NUM_PAIR-1:0]     lpSync;
	logic                     colSync;
	logic [`NUM_PORTS-1:0]    secSync;
	logic                     shcSync;
	logic [`NUM_PORTS-1:0]    rxStart;
	logic [`NUM_PAIR-1:0]     linkEvt;
	logic [`NUM_PAIR-1:0]     linkCheckOff;
	logic                     syncMode;
	logic                     localMgmt;
	logic [`NUM_PORTS-1:0]    scr;
	logic                     localCol;
	logic                     blinkPh;
	logic [`NUM_PORTS-1:0]    steadyRed;
	logic [`NUM_PORTS-1:0]    steadyGreen;
	logic [NENG-1:0][1:0]     engSym;
	logic [NENG-1:0]          engDrive;
	logic [NENG-1:0]          engNrz;
	logic [NENG-1:0]          engBusy;
	logic [NENG-1:0]          engReady;
	logic                     acc;
	logic [31:0]              statVec;

	port_link_if lnk[NENG] ();

	function automatic logic [1:0] lamp_drive(lamp_mode_t m, logic ph);
		// {level, oe_n}: high is green, low is red, released is dark
		unique case (m)
			L_OFF:     lamp_drive = 2'b01;
			L_GREEN:   lamp_drive = 2'b10;
			L_RED:     lamp_drive = 2'b00;
			L_BLINK_G: lamp_drive = ph ? 2'b10 : 2'b01;
			L_BLINK_R: lamp_drive = ph ? 2'b00 : 2'b01;
			L_ALT:     lamp_drive = ph ? 2'b10 : 2'b00;
		endcase
	endfunction : lamp_drive

	// synchronised pin levels, read only from the second stage
	assign rxSq    = st_ff.syncB[`SY_RX +: `NUM_PORTS];
	assign lpSync  = st_ff.syncB[`SY_LP +: `NUM_PAIR];
	assign colSync = st_ff.syncB[`SY_COL];
	assign secSync = st_ff.syncB[`SY_SEC +: `NUM_PORTS];
	assign shcSync = st_ff.syncB[`SY_SHC];

	assign linkCheckOff = st_ff.ctrl[`CTRL_LCO_LSB +: `NUM_PAIR];
	assign syncMode     = st_ff.ctrl[`CTRL_SYNC_BIT];
	assign localMgmt    = st_ff.ctrl[`CTRL_LOCAL_BIT];
	assign rxStart      = st_ff.rxActive & ~st_ff.rxPrev;
	assign linkEvt      = rxStart[`NUM_PAIR-1:0] | (lpSync & ~st_ff.lpPrev);
	assign blinkPh      = st_ff.blinkCnt[BLINK_BIT];

	assign scr[`NUM_PAIR-1:0] = secSync[`NUM_PAIR-1:0];
	// in local mode the attach input is the head select, not security
	assign scr[`NUM_PAIR] = ~localMgmt & secSync[`NUM_PAIR];

	// two or more receivers at once, or the attach collision pair
	assign localCol = (|(st_ff.rxActive & (st_ff.rxActive - 5'h01)))
		| colSync;

	assign steadyRed   = {colSync, polarityRev};
	assign steadyGreen = {rxJabber, ~st_ff.linkFail};

	genvar g;
	generate
		for (g = 0; g < NENG; g++) begin : g_eng
			if (g < `NUM_PORTS) begin : g_port
				assign lnk[g].txEn     = coreTxEn[g];
				assign lnk[g].txData   = coreTxData[g];
				assign lnk[g].regen    = ~syncMode;
				assign lnk[g].scramble = scr[g];
				assign lnk[g].allowTx  =
					(g >= `NUM_PAIR) || !st_ff.linkFail[g % `NUM_PAIR];
				assign lnk[g].pulseEn  = (g < `NUM_PAIR);
			end else begin : g_bpl
				// rebuilt receive stream for the other repeaters
				assign lnk[g].txEn     = syncMode & coreRxEn;
				assign lnk[g].txData   = coreRxData;
				assign lnk[g].regen    = 1'b1;
				assign lnk[g].scramble = 1'b0;
				assign lnk[g].allowTx  = 1'b1;
				assign lnk[g].pulseEn  = 1'b0;
			end
			assign engSym[g]   = lnk[g].symbol;
			assign engDrive[g] = lnk[g].drive;
			assign engNrz[g]   = lnk[g].nrzOut;
			assign engBusy[g]  = lnk[g].busy;
			assign engReady[g] = lnk[g].txReady;
			port_frame_tx #(
				.PULSE_CYCLES(LINK_PULSE_CYCLES)
			) u_tx (
				.clk_sys(clk_sys),
				.rst    (rst),
				.ce     (ce),
				.lnk    (lnk[g])
			);
		end
	endgenerate

	always_comb begin
		statVec = '0;
		statVec[`STAT_RX_LSB +: `NUM_PORTS] = st_ff.rxActive;
		statVec[`STAT_LF_LSB +: `NUM_PAIR]  = st_ff.linkFail;
		statVec[`STAT_COL_BIT]              = st_ff.collision;
		statVec[`STAT_LCOL_BIT]             = st_ff.colDrive;
		statVec[`STAT_BUSY_LSB +: `NUM_PORTS] = engBusy[`NUM_PORTS-1:0];
	end

	assign acc = hsel & htrans[1] & hready;

	always_comb begin
		lamp_mode_t mode;
		mode = L_OFF;
		nxt_st = st_ff;
		nxt_st.syncA = {shared_collision_line_n_i, secure_attach_port_in,
			port_scramble_in, attach_collision_pair, linkPulseIn,
			network_input_pair};
		nxt_st.syncB = st_ff.syncA;
		nxt_st.rxPrev = st_ff.rxActive;
		nxt_st.lpPrev = lpSync;
		// receivers wake on signal, sleep after a run of quiet bits
		for (int i = 0; i < `NUM_PORTS; i++) begin
			if (rxSq[i]) begin
				nxt_st.rxActive[i] = 1'b1;
				nxt_st.quietCnt[i] = '0;
			end else if (st_ff.rxActive[i]) begin
				if (st_ff.quietCnt[i] == 4'(`QUIET_BITS - 1)) begin
					nxt_st.rxActive[i] = 1'b0;
					nxt_st.quietCnt[i] = '0;
				end else begin
					nxt_st.quietCnt[i] = st_ff.quietCnt[i] + 4'h1;
				end
			end
		end
		for (int i = 0; i < `NUM_PAIR; i++) begin
			if (linkCheckOff[i]) begin
				nxt_st.linkFail[i] = 1'b0;
				nxt_st.failTmr[i] = '0;
				nxt_st.recovCnt[i] = '0;
			end else if (!st_ff.linkFail[i]) begin
				if (linkEvt[i]) begin
					nxt_st.failTmr[i] = '0;
				end else if (st_ff.failTmr[i] ==
						20'(LINK_FAIL_CYCLES - 1)) begin
					nxt_st.linkFail[i] = 1'b1;
					nxt_st.failTmr[i] = '0;
					nxt_st.recovCnt[i] = '0;
				end else begin
					nxt_st.failTmr[i] = st_ff.failTmr[i] + 20'h0_0001;
				end
			end else if (linkEvt[i]) begin
				if (st_ff.recovCnt[i] == 2'(`RECOVER_EVENTS - 1)) begin
					nxt_st.linkFail[i] = 1'b0;
					nxt_st.failTmr[i] = '0;
				end else begin
					nxt_st.recovCnt[i] = st_ff.recovCnt[i] + 2'h1;
				end
			end
		end
		nxt_st.colDrive = localCol;
		// remote repeaters pull the shared line low on their collisions
		nxt_st.collision = localCol | ~shcSync;
		nxt_st.chainHead = localMgmt & secSync[`NUM_PAIR];
		nxt_st.bpActN = ~(|st_ff.rxActive);
		nxt_st.bpDataN = ~engNrz[`NUM_PORTS];
		nxt_st.bpDrvN = ~engDrive[`NUM_PORTS];
		nxt_st.blinkCnt = st_ff.blinkCnt + 21'h00_0001;
		for (int i = 0; i < `NUM_PORTS; i++) begin
			if (partitioned[i]) begin
				mode = L_ALT;
			end else if (st_ff.rxActive[i]) begin
				mode = L_BLINK_R;
			end else if (engBusy[i]) begin
				mode = L_BLINK_G;
			end else if (steadyRed[i]) begin
				mode = L_RED;
			end else if (steadyGreen[i]) begin
				mode = L_GREEN;
			end else begin
				mode = L_OFF;
			end
			{nxt_st.lampLevel[i], nxt_st.lampOen[i]} =
				lamp_drive(mode, blinkPh);
		end
		if (st_ff.collision) begin
			mode = L_RED;
		end else if (fifoError) begin
			mode = L_GREEN;
		end else begin
			mode = L_OFF;
		end
		{nxt_st.lampLevel[`NUM_PORTS], nxt_st.lampOen[`NUM_PORTS]} =
			lamp_drive(mode, blinkPh);
		if (transceiver_jabber_lockup) begin
			mode = L_RED;
		end else if (codeViolation) begin
			mode = L_GREEN;
		end else begin
			mode = L_OFF;
		end
		{nxt_st.lampLevel[`NUM_PORTS+1], nxt_st.lampOen[`NUM_PORTS+1]} =
			lamp_drive(mode, blinkPh);
		// bus slave: address phase latched, write lands in data phase
		nxt_st.wrPend = acc & hwrite;
		if (acc && hwrite) begin
			nxt_st.wrCtrl = (haddr[7:0] == `REG_CTRL);
		end
		if (st_ff.wrPend && st_ff.wrCtrl) begin
			nxt_st.ctrl = hwdata[`CTRL_W-1:0];
		end
		if (acc && !hwrite) begin
			if (haddr[7:0] == `REG_CTRL) begin
				nxt_st.rdData = {26'h000_0000, st_ff.ctrl};
			end else if (haddr[7:0] == `REG_STAT) begin
				nxt_st.rdData = statVec;
			end else begin
				nxt_st.rdData = '0;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_ff <= HUB_RST;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	// wait states while frozen keep the master from losing a transfer
	assign hreadyout = ce;
	assign hresp     = 1'b0;
	assign hrdata    = st_ff.rdData;

	assign coreTxReady        = engReady[`NUM_PORTS-1:0];
	assign coreRxReady        = engReady[`NUM_PORTS];
	assign pairTxSymbol       = engSym[`NUM_PAIR-1:0];
	assign attach_output_pair = engSym[`NUM_PAIR];
	assign txDrive            = engDrive[`NUM_PORTS-1:0];

	assign shared_collision_line_n_o    = 1'b0;
	assign shared_collision_line_n_oe_n = ~st_ff.colDrive;
	assign backplane_activity_n         = st_ff.bpActN;
	assign backplane_serial_data_n      = st_ff.bpDataN;
	assign backplane_data_drive_n       = st_ff.bpDrvN;
	assign chain_head_select            = st_ff.chainHead;

	assign pair_port_lamp           = st_ff.lampLevel[`NUM_PAIR-1:0];
	assign pair_port_lamp_oe_n      = st_ff.lampOen[`NUM_PAIR-1:0];
	assign attach_port_lamp         = st_ff.lampLevel[`NUM_PAIR];
	assign attach_port_lamp_oe_n    = st_ff.lampOen[`NUM_PAIR];
	assign collision_fifo_lamp      = st_ff.lampLevel[`NUM_PORTS];
	assign collision_fifo_lamp_oe_n = st_ff.lampOen[`NUM_PORTS];
	assign jam_violation_lamp       = st_ff.lampLevel[`NUM_PORTS+1];
	assign jam_violation_lamp_oe_n  = st_ff.lampOen[`NUM_PORTS+1];
endmodule : hub_port_link_and_status

// File: hub_port_chk.sv
// concurrent checks on the hub port link and status block
module hub_port_chk #(
	parameter int LINK_FAIL_CYCLES = 200 // silence timeout
) (
	input wire logic            clk_sys,  // system clock
	input wire logic            rst,      // async reset
	input wire logic [4:0]      network_input_pair, // receivers
	input wire logic            attach_collision_pair, // col in
	input wire logic            fifoError,  // fifo fault
	input wire logic            secure_attach_port_in, // shared
	input wire logic [4:0]      partitioned, // isolated
	input wire logic [3:0]      linkPulseIn, // pulses
	input wire logic [4:0]      coreTxReady, // bit taken
	input wire logic [4:0]      txDrive,     // line driven
	input wire logic [1:0]      attach_output_pair, // symbol
	input wire logic [3:0][1:0] pairTxSymbol, // symbols
	input wire logic            shared_collision_line_n_o, // level
	input wire logic            shared_collision_line_n_oe_n, // en
	input wire logic            chain_head_select, // head
	input wire logic [3:0]      pair_port_lamp, // level
	input wire logic            collision_fifo_lamp, // level
	input wire logic            collision_fifo_lamp_oe_n // enable
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic [7:0]  quietCnt_ff;
	logic [19:0] silentCnt_ff;
	// both saturate so a long idle never wraps back into range
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			quietCnt_ff  <= 8'h00;
			silentCnt_ff <= 20'h0_0000;
		end else begin
			quietCnt_ff  <= (|network_input_pair || attach_collision_pair)
				? 8'h00 : quietCnt_ff + {7'h00, quietCnt_ff != 8'hff};
			silentCnt_ff <= (linkPulseIn[0] || network_input_pair[0])
				? 20'h0_0000 : silentCnt_ff + {19'h0_0000, ~&silentCnt_ff};
		end
	end
	a_two_rx_col: assert property (($countones(network_input_pair) > 1)[*7]
		|-> !shared_collision_line_n_oe_n) else $error("no collision drive");
	a_attach_col: assert property (attach_collision_pair[*6]
		|-> !shared_collision_line_n_oe_n) else $error("attach col lost");
	a_open_drain: assert property (!shared_collision_line_n_oe_n
		|-> !shared_collision_line_n_o) else $error("line driven high");
	a_quiet_idle: assert property (quietCnt_ff >= 8'h10
		|-> shared_collision_line_n_oe_n) else $error("receiver stuck");
	// port 0 only: the bench never turns its supervision off
	a_silence_fail: assert property (silentCnt_ff > LINK_FAIL_CYCLES + 8
		|-> !coreTxReady[0]) else $error("sends after silence");
	a_preamble_len: assert property ($rose(coreTxReady[4])
		|-> $past(txDrive[4], 56)) else $error("short preamble");
	a_manchester: assert property (txDrive[4] && !secure_attach_port_in
		|-> attach_output_pair inside {2'h1, 2'h2}) else $error("bad symbol");
	a_idle_symbol: assert property (!txDrive[0]
		|-> pairTxSymbol[0] == 2'h0) else $error("idle line not quiet");
	a_head_clear: assert property (!secure_attach_port_in[*4]
		|-> !chain_head_select) else $error("head without select");
	// a lamp phase bit of 2 flips the level every 4 cycles
	a_part_alt: assert property (partitioned[0][*6]
		|-> pair_port_lamp[0] != $past(pair_port_lamp[0], 4)) else $error("no alternation");
	a_col_lamp: assert property ((attach_collision_pair && !fifoError)[*6]
		|-> !collision_fifo_lamp_oe_n && !collision_fifo_lamp)
		else $error("collision lamp off");
	c_frame: cover property ($rose(coreTxReady[4]));
	c_col: cover property ($fell(shared_collision_line_n_oe_n));
	c_part: cover property (partitioned[0][*4]);
endmodule : hub_port_chk
bind hub_port_link_and_status hub_port_chk #(
	.LINK_FAIL_CYCLES(LINK_FAIL_CYCLES)) u_chk (.*);

// File: hub_far_side.sv
// far side model: pair segments and other repeaters on the shared line
module hub_far_side #(
	parameter int PERIOD = 50 // link pulse spacing in cycles
) (
	input  wire logic       clk_sys,   // system clock
	input  wire logic [3:0] pulseOn,   // segments sending link pulses
	input  wire logic       remoteCol, // another repeater pulls low
	input  wire logic       colOeN,    // our open-drain enable
	output logic [3:0]      linkPulse, // detected link pulses
	output logic            colLine    // wired line level
);
	timeunit 1ns;
	timeprecision 1ns;
	int tick = 0;
	initial linkPulse = 4'h0;
	// pull-up wins only when no party pulls low
	assign colLine = colOeN && !remoteCol;
	always @(posedge clk_sys) begin
		tick <= (tick == PERIOD - 1) ? 0 : tick + 1;
		linkPulse <= (tick == 0) ? pulseOn : 4'h0;
	end
endmodule : hub_far_side

// File: hub_port_link_and_status_tb_top.sv
// self-checking bench of the hub port link and status block
module hub_port_link_and_status_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic hready, hreadyout, hresp, coreRxEn = 1'b0, coreRxReady;
	logic rxJabber = 1'b0, fifoError = 1'b0, codeViolation = 1'b0;
	logic transceiver_jabber_lockup = 1'b0, attach_collision_pair = 1'b0;
	logic secure_attach_port_in = 1'b0, coreRxData = 1'b1, remoteCol = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata;
	logic [1:0] htrans = '0, attach_output_pair;
	logic [2:0] hsize = 3'h2;
	logic [4:0] coreTxEn = '0, coreTxData = '1, coreTxReady, txDrive;
	logic [4:0] partitioned = '0, network_input_pair = '0;
	logic [3:0] linkPulseIn, port_scramble_in = '0, polarityRev = '0;
	logic [3:0] pulseOn = '0, pair_port_lamp, pair_port_lamp_oe_n;
	logic [3:0][1:0] pairTxSymbol;
	logic shared_collision_line_n_i, shared_collision_line_n_o;
	logic shared_collision_line_n_oe_n, backplane_activity_n;
	logic backplane_serial_data_n, backplane_data_drive_n, chain_head_select;
	logic attach_port_lamp, attach_port_lamp_oe_n, collision_fifo_lamp;
	logic collision_fifo_lamp_oe_n, jam_violation_lamp, jam_violation_lamp_oe_n;
	int fail_count = 0, tests_run = 0, cyc = 0;
	assign hready = hreadyout;
	hub_port_link_and_status #(.LINK_FAIL_CYCLES(200), .LINK_PULSE_CYCLES(50),
		.BLINK_BIT(2)) dut (.*);
	hub_far_side #(.PERIOD(50)) far (.clk_sys(clk_sys), .pulseOn(pulseOn),
		.remoteCol(remoteCol), .colOeN(shared_collision_line_n_oe_n),
		.linkPulse(linkPulseIn), .colLine(shared_collision_line_n_i));
	always #50 clk_sys = ~clk_sys;
	task automatic stop_test();
		if (fail_count == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : stop_test
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 6000) begin
			fail_count++;
			stop_test();
		end
	end
	task automatic chk(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		hsel   <= 1'b1;
		haddr  <= {24'h00_0000, a};
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge clk_sys); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hready !== 1'b1);
		q = hrdata;
	endtask : bus
	// one data bit, so the engine must pad the rest of the frame
	task automatic frame(output int pre, output int len, output int bad);
		pre = 0;
		bad = 0;
		coreTxEn[4] <= 1'b1;
		do begin
			@(posedge clk_sys);
			pre += txDrive[4];
			if (txDrive[4] && pre <= 56 &&
				attach_output_pair !== (pre[0] ? 2'h1 : 2'h2)) bad++;
		end while (coreTxReady[4] !== 1'b1 && pre < 200);
		coreTxEn[4] <= 1'b0;
		len = pre;
		do begin
			@(posedge clk_sys);
			len += txDrive[4];
		end while (txDrive[4] && len < 200);
	endtask : frame
	initial begin
		logic [31:0] q;
		int p, l, b;
		tick(8);
		rst <= 1'b0;
		tick(1);
		bus(1'b0, 8'h00, '0, q);
		chk(q === 32'h0000_0020, "ctrl reset");
		bus(1'b0, 8'h04, '0, q);
		chk(q[8:5] === 4'hf, "link fail at reset");
		bus(1'b0, 8'h40, '0, q);
		chk(q === 32'h0000_0000, "unmapped read");
		pulseOn <= 4'h1;
		tick(60);
		bus(1'b0, 8'h04, '0, q);
		chk(q[5] === 1'b1, "left fail early");
		tick(140);
		bus(1'b0, 8'h04, '0, q);
		chk(q[5] === 1'b0, "no recovery");
		pulseOn <= 4'h0;
		tick(260);
		bus(1'b0, 8'h04, '0, q);
		chk(q[5] === 1'b1, "no link fail");
		bus(1'b1, 8'h00, 32'h0000_0028, q);
		tick(4);
		bus(1'b0, 8'h04, '0, q);
		chk(q[8] === 1'b0, "check off ignored");
		bus(1'b1, 8'h00, 32'h0000_0020, q);
		frame(p, l, b);
		chk(p >= 56 && b == 0, "preamble");
		chk(l == 96, "pad length");
		bus(1'b1, 8'h00, 32'h0000_0000, q);
		secure_attach_port_in <= 1'b1;
		tick(4);
		frame(p, l, b);
		chk(b != 0, "not scrambled");
		secure_attach_port_in <= 1'b0;
		tick(4);
		frame(p, l, b);
		chk(b == 0, "scramble stuck");
		bus(1'b1, 8'h00, 32'h0000_0020, q);
		secure_attach_port_in <= 1'b1;
		tick(4);
		chk(chain_head_select === 1'b1, "head select");
		secure_attach_port_in <= 1'b0;
		network_input_pair <= 5'h03;
		tick(10);
		bus(1'b0, 8'h04, '0, q);
		chk(q[10:9] === 2'h3 && !backplane_activity_n, "two rx collision");
		network_input_pair <= 5'h00;
		tick(20);
		chk(shared_collision_line_n_oe_n === 1'b1, "rx not idle");
		remoteCol <= 1'b1;
		tick(5);
		bus(1'b0, 8'h04, '0, q);
		chk(q[10:9] === 2'h1, "remote collision");
		{remoteCol, attach_collision_pair} <= 2'b01;
		bus(1'b1, 8'h00, 32'h0000_0030, q);
		coreRxEn <= 1'b1;
		p = 0;
		do begin
			@(posedge clk_sys);
			p += !backplane_data_drive_n;
		end while (coreRxReady !== 1'b1 && p < 200);
		{coreRxEn, attach_collision_pair} <= 2'b00;
		chk(p >= 56, "backplane preamble");
		chk(collision_fifo_lamp === 1'b0 && !collision_fifo_lamp_oe_n, "col");
		tick(60);
		partitioned[0] <= 1'b1;
		tick(6);
		chk(pair_port_lamp_oe_n[0] === 1'b0, "partition lamp");
		partitioned[0] <= 1'b0;
		fifoError <= 1'b1;
		codeViolation <= 1'b1;
		tick(4);
		chk(collision_fifo_lamp === 1'b1 && !collision_fifo_lamp_oe_n, "fifo");
		chk(jam_violation_lamp === 1'b1 && !jam_violation_lamp_oe_n, "cv");
		stop_test();
	end
endmodule : hub_port_link_and_status_tb_top
